// *** bench/ias_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// core stack and vector memory
// ****************************************
module ias_core_model
  import ias_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // memory port
  input wire ias_mem_t mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:511];
  wire vec_area = (mem.addr[15:8] == 8'hFF);
  assign mem_rdata = vec_area ? (mem.addr[7:0] ^ 8'h5A) : ram[mem.addr[8:0]];
  always @(posedge clk_sys) begin
    if (mem.we) begin
      ram[mem.addr[8:0]] <= mem.data;
    end
  end
  initial begin
    for (int i = 0; i < 512; i++) begin
      ram[i] = 8'hC3;
    end
  end
endmodule : ias_core_model
`default_nettype wire

// *** bench/ias_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// acceptance sequencer bench
// ****************************************
module ias_top_tb_top
  import ias_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  ias_bus_t bus = '0;
  logic [7:0] rd_data, status_out, mem_rdata;
  logic [15:0] src_req = '0;
  logic timer4_request = 1'b0;
  logic ext_input3_request = 1'b0;
  logic nmi_req = 1'b0;
  logic instr_last = 1'b0;
  logic ret_mask = 1'b0;
  logic accept_busy, pc_load, status_load, irq;
  logic [15:0] pc_out;
  ias_mem_t mem;
  int failures = 0;
  int checks_done = 0;
  int n;
  int busy_seen;
  always #12.5 clk_sys = ~clk_sys;
  ias_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .rd_data(rd_data), .src_req(src_req),
    .timer4_request(timer4_request), .ext_input3_request(ext_input3_request), .nmi_req(nmi_req),
    .instr_last(instr_last), .pc_in(16'h1234), .status_in(8'h5A), .ret_mask(ret_mask),
    .ret_nonmask(1'b0), .accept_busy(accept_busy), .pc_load(pc_load), .pc_out(pc_out),
    .status_load(status_load), .status_out(status_out), .mem(mem), .mem_rdata(mem_rdata), .irq(irq));
  ias_core_model i_core (.clk_sys(clk_sys), .mem(mem), .mem_rdata(mem_rdata));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) bus.wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) bus.rd <= 1'b0;
    #1 chk(what, {8'h00, rd_data}, {8'h00, exp});
  endtask : rchk
  task automatic pulse(input int k);
    @(posedge clk_sys);
    case (k)
      16: timer4_request <= 1'b1;
      17: ext_input3_request <= 1'b1;
      18: nmi_req <= 1'b1;
      19: instr_last <= 1'b1;
      20: ret_mask <= 1'b1;
      default: src_req <= 16'h0001 << k;
    endcase
    @(posedge clk_sys);
    {timer4_request, ext_input3_request, nmi_req, instr_last, ret_mask} <= '0;
    src_req <= '0;
  endtask : pulse
  task automatic take(input int k, output int cnt);
    pulse(k);
    cnt = 1;
    busy_seen = 0;
    #1;
    while (pc_load !== 1'b1 && cnt < 20) begin
      if (accept_busy === 1'b1) begin
        busy_seen++;
      end
      @(posedge clk_sys);
      cnt++;
      #1;
    end
  endtask : take
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    #50us;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk(8'h3E, 8'h00, "select");
    rchk(8'h42, 8'hFF, "sp");
    wr(8'h3E, 8'h10);
    rchk(8'h3E, 8'h10, "select");
    wr(8'h3E, 8'h00);
    pulse(17);
    rchk(8'h3D, 8'h00, "latch_hi");
    pulse(16);
    rchk(8'h3D, 8'h08, "latch_hi");
    wr(8'h3D, 8'h00);
    rchk(8'h3D, 8'h00, "latch_hi");
    wr(8'h3E, 8'h10);
    pulse(16);
    rchk(8'h3D, 8'h00, "latch_hi");
    pulse(17);
    rchk(8'h3D, 8'h08, "latch_hi");
    wr(8'h3B, 8'h08);
    wr(8'h3A, 8'h01);
    wr(8'h41, 8'h01);
    take(19, n);
    chk("cycles", 16'(n), 16'd8);
    chk("busy", 16'(busy_seen), 16'd7);
    chk("vector", pc_out, 16'hB3B2);
    chk("push_psw", 16'(i_core.ram[9'h0FF]), 16'h005B);
    chk("push_pch", 16'(i_core.ram[9'h0FE]), 16'h0012);
    chk("push_pcl", 16'(i_core.ram[9'h0FD]), 16'h0034);
    rchk(8'h42, 8'hFC, "sp");
    rchk(8'h3D, 8'h00, "latch_hi");
    rchk(8'h3A, 8'h00, "enable_lo");
    chk("irq", 16'(irq), 16'h0001);
    wr(8'h40, 8'h01);
    #1 chk("irq", 16'(irq), 16'h0000);
    wr(8'h3A, 8'h20);
    pulse(5);
    take(19, n);
    chk("blocked", 16'(n), 16'd20);
    rchk(8'h3C, 8'h20, "latch_lo");
    pulse(18);
    take(19, n);
    chk("nmi_vector", pc_out, 16'hA5A4);
    wr(8'h3B, 8'h02);
    wr(8'h3A, 8'h21);
    pulse(9);
    take(19, n);
    chk("priority", pc_out, 16'hAFAE);
    rchk(8'h3D, 8'h02, "latch_hi");
    rchk(8'h42, 8'hF6, "sp");
    take(20, n);
    chk("ret_pc", pc_out, 16'h1234);
    chk("ret_load", 16'(status_load), 16'h0001);
    chk("ret_status", 16'(status_out), 16'h005B);
    rchk(8'h42, 8'hF9, "sp");
    rchk(8'h3A, 8'h21, "enable_lo");
    give_verdict();
  end
endmodule : ias_top_tb_top
`default_nettype wire

// *** design/ias_defs.svh ***
`ifndef IAS_DEFS_SVH
`define IAS_DEFS_SVH
// ****************************************
// register offsets
// ****************************************
`define IAS_OFF_SELECT 8'h3E
`define IAS_OFF_LATCH_LO 8'h3C
`define IAS_OFF_LATCH_HI 8'h3D
`define IAS_OFF_ENABLE_LO 8'h3A
`define IAS_OFF_ENABLE_HI 8'h3B
`define IAS_OFF_STATUS 8'h40
`define IAS_OFF_MASK 8'h41
`define IAS_OFF_SP 8'h42
`define IAS_OFF_PSW 8'h43
// ****************************************
// fields and reset values
// ****************************************
`define IAS_SEL_BIT 4
`define IAS_SHARED_LEVEL 11
`define IAS_MEN_BIT 0
`define IAS_SELECT_RST 8'h00
`define IAS_SP_RST 16'h00FF
`define IAS_VEC_BASE 16'hFFE0
// ****************************************
// timing
// ****************************************
`define IAS_ACCEPT_CYCLES 8
`define IAS_PUSH_BYTES 3
`define IAS_WORST_FC 38
`endif

// *** design/ias_pkg.sv ***
package ias_pkg;
  typedef enum logic [2:0] {
    IAS_IDLE, IAS_MEN, IAS_PSW, IAS_PCH, IAS_PCL, IAS_VLO, IAS_VHI, IAS_LOAD
  } ias_state_t;
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } ias_mem_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ias_bus_t;
endpackage : ias_pkg

// *** design/ias_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ias_defs.svh"
module ias_top
  import ias_pkg::*;
#(
  parameter int NSRC = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire ias_bus_t bus,
  output logic [7:0] rd_data,
  // request sources, index is latch number; latch 11 takes the selected timer4/ext3 request, not src_req[11]
  input wire logic [NSRC-1:0] src_req,
  input wire logic timer4_request,
  input wire logic ext_input3_request,
  input wire logic nmi_req,
  // core handshake
  input wire logic instr_last,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] status_in,
  input wire logic ret_mask,
  input wire logic ret_nonmask,
  output logic accept_busy,
  output logic pc_load,
  output logic [15:0] pc_out,
  output logic status_load,
  output logic [7:0] status_out,
  // memory port
  output ias_mem_t mem,
  input wire logic [7:0] mem_rdata,
  // interrupt
  output logic irq
);
  ias_state_t state_r, state_nxt;
  logic [NSRC-1:0] latch_r, enable_r;
  logic master_enable_flag_r;
  logic [7:0] select_r, stat_r, mask_r;
  logic [15:0] sp_r, pc_r, vec_r;
  logic [3:0] src_r;
  logic nmi_r, nmi_pend_r, ret_busy_r;
  logic [1:0] ret_cnt_r;
  logic [7:0] rd_data_nxt;
  logic men_saved_r;
  logic [15:0] pc_out_r;
  logic [7:0] status_out_r;
  logic pc_load_r, status_load_r;

  function automatic logic [3:0] pick(input logic [NSRC-1:0] v);
    logic [3:0] p;
    p = 4'h0;
    for (int i = NSRC-1; i >= 0; i--) begin
      if (v[i]) begin
        p = 4'(i);
      end
    end
    return p;
  endfunction : pick

  // ****************************************
  // request capture
  // ****************************************
  wire sel_ext3 = select_r[`IAS_SEL_BIT];
  wire shared_req = sel_ext3 ? ext_input3_request : timer4_request;
  logic [NSRC-1:0] req_vec;
  always_comb begin
    req_vec = src_req;
    req_vec[`IAS_SHARED_LEVEL] = shared_req;
  end
  wire [NSRC-1:0] ready_vec = latch_r & enable_r & {NSRC{master_enable_flag_r}};
  wire [3:0] win = pick(ready_vec);
  wire take_nmi = nmi_pend_r;
  wire take = instr_last && (state_r == IAS_IDLE) && !ret_busy_r && (take_nmi || (|ready_vec));
  wire wr_hit = bus.wr;
  wire sw_lat_lo = wr_hit && bus.addr == `IAS_OFF_LATCH_LO;
  wire sw_lat_hi = wr_hit && bus.addr == `IAS_OFF_LATCH_HI;
  wire [NSRC-1:0] sw_keep = {sw_lat_hi ? bus.wdata : 8'hFF, sw_lat_lo ? bus.wdata : 8'hFF};
  wire acc_clr = (state_r == IAS_PSW) && !nmi_r;
  logic [NSRC-1:0] acc_mask;
  always_comb begin
    acc_mask = '0;
    acc_mask[src_r] = acc_clr;
  end
  wire [NSRC-1:0] latch_nxt = ((latch_r & sw_keep) & ~acc_mask) | req_vec;

  // ****************************************
  // acceptance sequence
  // ****************************************
  // eight machine cycles
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      IAS_IDLE: begin
        if (take) begin
          state_nxt = IAS_MEN;
        end
      end
      IAS_MEN: state_nxt = IAS_PSW;
      IAS_PSW: state_nxt = IAS_PCH;
      IAS_PCH: state_nxt = IAS_PCL;
      IAS_PCL: state_nxt = IAS_VLO;
      IAS_VLO: state_nxt = IAS_VHI;
      IAS_VHI: state_nxt = IAS_LOAD;
      default: state_nxt = IAS_IDLE;
    endcase
  end
  wire [15:0] vec_addr = nmi_r ? `IAS_VEC_BASE + 16'h001E : `IAS_VEC_BASE + 16'(5'd30 - {src_r, 1'b0});
  always_comb begin
    mem = '0;
    mem.we = 1'b0;
    mem.addr = sp_r;
    mem.data = 8'h00;
    case (state_r)
      IAS_PSW: begin
        mem.we = 1'b1;
        mem.data = {status_in[7:1], men_saved_r};
      end
      IAS_PCH: begin
        mem.we = 1'b1;
        mem.data = pc_r[15:8];
      end
      IAS_PCL: begin
        mem.we = 1'b1;
        mem.data = pc_r[7:0];
      end
      IAS_VLO: mem.addr = vec_addr;
      IAS_VHI: mem.addr = vec_addr + 16'h0001;
      default: mem.addr = sp_r + 16'h0001;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  wire ev_accept = state_r == IAS_LOAD;
  wire ev_drop = (sel_ext3 ? timer4_request : ext_input3_request);
  wire [7:0] stat_set = {6'h00, ev_drop, ev_accept};
  wire [7:0] stat_clr = (wr_hit && bus.addr == `IAS_OFF_STATUS) ? bus.wdata : 8'h00;
  always_comb begin
    rd_data_nxt = 8'h00;
    if (bus.addr == `IAS_OFF_SELECT) begin
      rd_data_nxt = select_r & 8'hDF;
    end else if (bus.addr == `IAS_OFF_LATCH_LO) begin
      rd_data_nxt = latch_r[7:0];
    end else if (bus.addr == `IAS_OFF_LATCH_HI) begin
      rd_data_nxt = latch_r[15:8];
    end else if (bus.addr == `IAS_OFF_ENABLE_LO) begin
      rd_data_nxt = {enable_r[7:1], master_enable_flag_r};
    end else if (bus.addr == `IAS_OFF_ENABLE_HI) begin
      rd_data_nxt = enable_r[15:8];
    end else if (bus.addr == `IAS_OFF_STATUS) begin
      rd_data_nxt = stat_r;
    end else if (bus.addr == `IAS_OFF_MASK) begin
      rd_data_nxt = mask_r;
    end else if (bus.addr == `IAS_OFF_SP) begin
      rd_data_nxt = sp_r[7:0];
    end
    if (!bus.rd) begin
      rd_data_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_r <= IAS_IDLE;
      latch_r <= '0;
      enable_r <= '0;
      master_enable_flag_r <= 1'b0;
      select_r <= `IAS_SELECT_RST;
      stat_r <= 8'h00;
      mask_r <= 8'h00;
      sp_r <= `IAS_SP_RST;
      pc_r <= 16'h0000;
      vec_r <= 16'h0000;
      src_r <= 4'h0;
      nmi_r <= 1'b0;
      nmi_pend_r <= 1'b0;
      ret_busy_r <= 1'b0;
      ret_cnt_r <= 2'd0;
      rd_data <= 8'h00;
      pc_out_r <= 16'h0000;
      status_out_r <= 8'h00;
      pc_load_r <= 1'b0;
      status_load_r <= 1'b0;
      men_saved_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      latch_r <= latch_nxt;
      rd_data <= rd_data_nxt;
      stat_r <= (stat_r & ~stat_clr) | stat_set;
      pc_load_r <= ev_accept;
      status_load_r <= 1'b0;
      nmi_pend_r <= (nmi_pend_r && !(take && take_nmi)) || nmi_req;
      if (wr_hit && bus.addr == `IAS_OFF_SELECT) begin
        select_r <= bus.wdata & 8'hDF;
      end
      if (wr_hit && bus.addr == `IAS_OFF_MASK) begin
        mask_r <= bus.wdata;
      end
      if (wr_hit && bus.addr == `IAS_OFF_ENABLE_HI) begin
        enable_r[15:8] <= bus.wdata;
      end
      if (wr_hit && bus.addr == `IAS_OFF_ENABLE_LO) begin
        enable_r[7:1] <= bus.wdata[7:1];
        master_enable_flag_r <= bus.wdata[`IAS_MEN_BIT];
      end
      if (take) begin
        src_r <= win;
        nmi_r <= take_nmi;
        pc_r <= pc_in;
        men_saved_r <= master_enable_flag_r;
      end
      if (state_r == IAS_MEN) begin
        master_enable_flag_r <= 1'b0;
      end
      if (mem.we) begin
        sp_r <= sp_r - 16'h0001;
      end
      if (state_r == IAS_VLO) begin
        vec_r[7:0] <= mem_rdata;
      end
      if (state_r == IAS_VHI) begin
        vec_r[15:8] <= mem_rdata;
      end
      if (ev_accept) begin
        pc_out_r <= vec_r;
      end
      if (state_r == IAS_IDLE && !take && !ret_busy_r && (ret_mask || ret_nonmask)) begin
        ret_busy_r <= 1'b1;
        ret_cnt_r <= 2'd0;
      end else if (ret_busy_r) begin
        sp_r <= sp_r + 16'h0001;
        ret_cnt_r <= ret_cnt_r + 2'd1;
        if (ret_cnt_r == 2'd0) begin
          pc_out_r[7:0] <= mem_rdata;
        end else if (ret_cnt_r == 2'd1) begin
          pc_out_r[15:8] <= mem_rdata;
        end else begin
          status_out_r <= mem_rdata;
          master_enable_flag_r <= mem_rdata[`IAS_MEN_BIT];
          status_load_r <= 1'b1;
          pc_load_r <= 1'b1;
          ret_busy_r <= 1'b0;
        end
      end
    end
  end

  assign accept_busy = state_r != IAS_IDLE;
  assign pc_load = pc_load_r;
  assign pc_out = pc_out_r;
  assign status_load = status_load_r;
  assign status_out = status_out_r;
  assign irq = |(stat_r & mask_r);

  // ****************************************
  // checks
  // ****************************************
  // sequence length
  a_accept_len: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take |=> (state_r != IAS_IDLE) [*7] ##1 state_r == IAS_IDLE) else $error("accept length wrong");
  a_master_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_r == IAS_MEN |=> !master_enable_flag_r) else $error("master not cleared");
  a_sp_down: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take |-> ##5 sp_r == $past(sp_r, 3) - 16'h0003) else $error("sp not minus 3");
  a_no_mask: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == IAS_PSW && !nmi_r) |-> $past(master_enable_flag_r, 2)) else $error("masked accept");
  a_latch_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (acc_clr && !req_vec[src_r]) |=> !latch_r[$past(src_r)]) else $error("latch kept");
  a_sel_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!latch_r[`IAS_SHARED_LEVEL] && !shared_req) |=> !latch_r[`IAS_SHARED_LEVEL]) else $error("unselected latched");
  a_latch_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (latch_r[5] && !sw_lat_lo && !(acc_clr && src_r == 4'h5)) |=> latch_r[5]) else $error("latch lost");
  a_vec_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ev_accept |=> pc_load && pc_out == $past(vec_r)) else $error("vector not loaded");
endmodule : ias_top
`default_nettype wire
